// File: logic/rtc_cal_hour_month.sv
// Hour, day, weekday and month counters of the real-time clock calendar.
// Assumes a minute-rollover carry pulse, the year counter value and the
// host access-in-progress level all come synchronous to mclk_i.
//
// Contract
// [R01] Unimplemented counter bits read back as zero
// [R02] Counters not reset; reset leaves them unchanged
// [R03] 24-hour: hours 0-23 BCD, tens bits 5:4
// [R04] 12-hour: hours 1-12 BCD, tens bit 4
// [R05] 12-hour: bit 5 meridiem flag, 1 is PM
// [R06] Format select input chooses 12 or 24 hour
// [R07] Day 1-31 BCD, tens bits 5:4
// [R08] Year divisible by four gives February 29
// [R09] Weekday 3-bit count 0 to 6
// [R10] Week increments when weekday moves to Monday
// [R11] Month 1-12 BCD, tens bit 4
// [R12] Host access freezes counting and carries
// [R13] One pending carry stored, applied on release
// [R14] Hour rollover advances day and weekday together
`timescale 1ns/10ps

module rtc_cal_hour_month
  import rtc_cal_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic hour_carry_i,
  input wire logic format_12h_i,
  input wire logic [7:0] year_i,
  input wire logic access_active_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic month_carry_o,
  output logic week_inc_o
);

  // ****************************************************************
  // BCD helpers
  // ****************************************************************

  // Next BCD value of a two-digit field; only valid digits expected
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r[3:0] = 4'h0;
      r[7:4] = v[7:4] + 4'h1;
    end else begin
      r[3:0] = v[3:0] + 4'h1;
    end
    return r;
  endfunction

  // Year multiple of four in BCD: (2*tens + units) mod 4 is zero
  function automatic logic is_leap(input logic [7:0] y);
    logic [1:0] s;
    s = y[1:0] + {y[4], 1'b0};
    return (s == 2'b00);
  endfunction

  // Last day of the month held in BCD
  function automatic logic [5:0] last_day(input logic [4:0] m, input logic leap);
    logic [5:0] r;
    r = DAYS_LONG;
    if (m == MONTH_FEB) begin
      r = leap ? DAYS_FEB_LEAP : DAYS_FEB; // [R08]
    end else if (m == MONTH_APR || m == MONTH_JUN || m == MONTH_SEP || m == MONTH_NOV) begin
      r = DAYS_SHORT;
    end
    return r;
  endfunction

  // ****************************************************************
  // Counter state
  // ****************************************************************
  logic [5:0] hour_q, hour_d;
  logic [5:0] day_q, day_d;
  logic [2:0] weekday_q, weekday_d;
  logic [4:0] month_q, month_d;
  logic pending_q, pending_d;
  logic month_carry_q, month_carry_d;
  logic week_inc_q, week_inc_d;
  logic [7:0] rdata_q, rdata_d;
  logic step;
  logic day_roll;
  logic [7:0] hour_inc, day_inc, month_inc;

  assign hour_inc = bcd_inc({2'b00, hour_q});
  assign day_inc = bcd_inc({2'b00, day_q});
  assign month_inc = bcd_inc({3'b000, month_q});

  // Advance only while no host access is open, so a read never sees a half-done carry
  always_comb begin
    step = 1'b0;
    pending_d = pending_q;
    if (access_active_i) begin
      pending_d = pending_q | hour_carry_i; // [R12] [R13]
    end else begin
      step = pending_q | hour_carry_i; // [R13]
      pending_d = pending_q & hour_carry_i; // Second carry waits one cycle
    end
  end

  // Next values of the counters, host writes win over counting
  always_comb begin
    hour_d = hour_q;
    day_d = day_q;
    weekday_d = weekday_q;
    month_d = month_q;
    month_carry_d = 1'b0;
    week_inc_d = 1'b0;
    day_roll = 1'b0;
    if (step) begin
      if (format_12h_i) begin // [R06]
        // [R04] [R05] 11 -> 12 flips meridiem; 12 -> 1 keeps it
        if (hour_q[4:0] == HOUR12_LAST) begin
          hour_d[4:0] = HOUR12_FIRST;
        end else begin
          hour_d[4:0] = hour_inc[4:0];
          if (hour_q[4:0] == HOUR12_NOON_PREV) begin
            hour_d[MERIDIEM_BIT] = ~hour_q[MERIDIEM_BIT];
            day_roll = hour_q[MERIDIEM_BIT]; // 11 PM to 12 AM ends the day
          end
        end
      end else begin
        if (hour_q == HOUR24_LAST) begin // [R03]
          hour_d = HOUR24_FIRST;
          day_roll = 1'b1;
        end else begin
          hour_d = hour_inc[5:0];
        end
      end
      if (day_roll) begin
        // [R14] Day and weekday move in the same cycle
        if (day_q == last_day(month_q, is_leap(year_i))) begin // [R07] [R08]
          day_d = DAY_FIRST;
          if (month_q == MONTH_LAST) begin // [R11]
            month_d = MONTH_FIRST;
            month_carry_d = 1'b1;
          end else begin
            month_d = month_inc[4:0];
          end
        end else begin
          day_d = day_inc[5:0];
        end
        if (weekday_q == WEEKDAY_LAST) begin // [R09]
          weekday_d = WEEKDAY_FIRST;
        end else begin
          weekday_d = weekday_q + 3'h1;
        end
        week_inc_d = (weekday_d == WEEKDAY_WEEK_START); // [R10]
      end
    end
    // Host writes keep only implemented bits
    if (reg_we_i) begin
      if (reg_addr_i == HOUR_COUNTER_OFS) begin
        hour_d = reg_wdata_i[5:0];
      end else if (reg_addr_i == DAY_COUNTER_OFS) begin
        day_d = reg_wdata_i[5:0];
      end else if (reg_addr_i == WEEKDAY_COUNTER_OFS) begin
        weekday_d = reg_wdata_i[2:0];
      end else if (reg_addr_i == MONTH_COUNTER_OFS) begin
        month_d = reg_wdata_i[4:0];
      end
    end
  end

  // Read data captured on a read strobe; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_re_i) begin
      if (reg_addr_i == HOUR_COUNTER_OFS) begin
        rdata_d = {2'b00, hour_q} & HOUR_MASK; // [R01]
      end else if (reg_addr_i == DAY_COUNTER_OFS) begin
        rdata_d = {2'b00, day_q} & DAY_MASK; // [R01]
      end else if (reg_addr_i == WEEKDAY_COUNTER_OFS) begin
        rdata_d = {5'b00000, weekday_q} & WEEKDAY_MASK; // [R01]
      end else if (reg_addr_i == MONTH_COUNTER_OFS) begin
        rdata_d = {3'b000, month_q} & MONTH_MASK; // [R01]
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Calendar counters carry no reset so a system reset keeps the date
  always_ff @(posedge mclk_i) begin
    hour_q <= hour_d; // [R02]
    day_q <= day_d; // [R02]
    weekday_q <= weekday_d; // [R02]
    month_q <= month_d; // [R02]
  end

  // Control and port state, synchronous active-low reset
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pending_q <= 1'b0;
      month_carry_q <= 1'b0;
      week_inc_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      pending_q <= pending_d;
      month_carry_q <= month_carry_d;
      week_inc_q <= week_inc_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign month_carry_o = month_carry_q;
  assign week_inc_o = week_inc_q;

endmodule // rtc_cal_hour_month

// File: logic/rtc_cal_pkg.sv
// Package for the hour-to-month calendar counters of the real-time clock.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package rtc_cal_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] HOUR_COUNTER_OFS = 8'h05;
  localparam logic [7:0] DAY_COUNTER_OFS = 8'h06;
  localparam logic [7:0] WEEKDAY_COUNTER_OFS = 8'h07;
  localparam logic [7:0] MONTH_COUNTER_OFS = 8'h08;

  // ****************************************************************
  // Field layouts (implemented-bit masks)
  // ****************************************************************
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] DAY_MASK = 8'h3f;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;
  localparam logic [7:0] MONTH_MASK = 8'h1f;
  localparam int MERIDIEM_BIT = 5;

  // ****************************************************************
  // Calendar values (BCD)
  // ****************************************************************
  localparam logic [5:0] HOUR24_LAST = 6'h23;
  localparam logic [5:0] HOUR24_FIRST = 6'h00;
  localparam logic [4:0] HOUR12_LAST = 5'h12;
  localparam logic [4:0] HOUR12_FIRST = 5'h01;
  localparam logic [4:0] HOUR12_NOON_PREV = 5'h11;
  localparam logic [5:0] DAY_FIRST = 6'h01;
  localparam logic [2:0] WEEKDAY_LAST = 3'h6;
  localparam logic [2:0] WEEKDAY_FIRST = 3'h0;
  localparam logic [2:0] WEEKDAY_WEEK_START = 3'h1;
  localparam logic [4:0] MONTH_FIRST = 5'h01;
  localparam logic [4:0] MONTH_LAST = 5'h12;
  localparam logic [4:0] MONTH_FEB = 5'h02;
  localparam logic [4:0] MONTH_APR = 5'h04;
  localparam logic [4:0] MONTH_JUN = 5'h06;
  localparam logic [4:0] MONTH_SEP = 5'h09;
  localparam logic [4:0] MONTH_NOV = 5'h11;
  localparam logic [5:0] DAYS_LONG = 6'h31;
  localparam logic [5:0] DAYS_SHORT = 6'h30;
  localparam logic [5:0] DAYS_FEB = 6'h28;
  localparam logic [5:0] DAYS_FEB_LEAP = 6'h29;

endpackage

// File: verification/rtc_cal_sva.sv
// Port checker for the calendar counter block.
// Assumes reset and host inputs move on the falling clock edge, DUT outputs on the rising one.
`timescale 1ns/10ps
module rtc_cal_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic access_active_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic month_carry_o,
  input wire logic week_inc_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Unused bits must read zero one cycle after the strobe
  a_unmapped_zero: assert property (reg_re_i && !(reg_addr_i inside {[8'h05:8'h08]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  a_hour_unused: assert property (reg_re_i && reg_addr_i == 8'h05 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("hour bits");
  a_day_unused: assert property (reg_re_i && reg_addr_i == 8'h06 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("day bits");
  a_weekday_unused: assert property (reg_re_i && reg_addr_i == 8'h07 |=> reg_rdata_o[7:3] == 5'h00)
    else $error("weekday bits");
  a_month_unused: assert property (reg_re_i && reg_addr_i == 8'h08 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("month bits");
  // Carries out are single-cycle pulses
  a_month_pulse: assert property (month_carry_o |=> !month_carry_o) else $error("month pulse");
  a_week_pulse: assert property (week_inc_o |=> !week_inc_o) else $error("week pulse");
  // A held access leaves no room for a step, so no carry may come out
  a_frozen_quiet: assert property (access_active_i [*3] |=> !month_carry_o && !week_inc_o)
    else $error("carry while frozen");
endmodule // rtc_cal_sva
bind rtc_cal_hour_month rtc_cal_sva i_sva (.mclk_i, .rst_b_i, .access_active_i, .reg_re_i, .reg_addr_i,
  .reg_rdata_o, .month_carry_o, .week_inc_o);

// File: verification/rtc_host_model.sv
// Host model making register accesses on the strobe port.
// Assumes the block takes strobes on the rising edge of clk_i.
`timescale 1ns/10ps
module rtc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic access_o = 1'b0,
  output logic we_o = 1'b0,
  output logic re_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // One access, stretched by n cycles; released lines flip so stale values never look fresh
  task automatic acc(input logic w, input logic [7:0] a, wd, input int n, output logic [7:0] rd);
    @(negedge clk_i);
    access_o = 1'b1;
    we_o = w;
    re_o = !w;
    addr_o = a;
    wdata_o = wd;
    @(negedge clk_i);
    we_o = 1'b0;
    re_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wd;
    repeat (n + 1) @(negedge clk_i);
    rd = rdata_i;
    access_o = 1'b0;
  endtask
endmodule // rtc_host_model

// File: verification/testbench.sv
// Self-checking bench for the hour-to-month counters.
// Assumes the host model makes every register access.
`timescale 1ns/10ps
module testbench;
  import rtc_cal_pkg::*;
  logic mclk_i, rst_b_i, hour_carry_i, format_12h_i, access_active_i, reg_we_i, reg_re_i;
  logic month_carry_o, week_inc_o;
  logic [7:0] year_i, reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  int errors, checks, week_cnt, month_cnt;
  rtc_cal_hour_month i_dut (.mclk_i, .rst_b_i, .hour_carry_i, .format_12h_i, .year_i, .access_active_i,
    .reg_we_i, .reg_re_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .month_carry_o, .week_inc_o);
  rtc_host_model i_host (.clk_i(mclk_i), .rdata_i(reg_rdata_o), .access_o(access_active_i), .we_o(reg_we_i),
    .re_o(reg_re_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  // Clock and a watchdog far beyond the few hundred cycles needed
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Count the carry pulses so the outputs are judged, not only the registers
  always @(posedge mclk_i) begin
    if (week_inc_o === 1'b1) week_cnt++;
    if (month_carry_o === 1'b1) month_cnt++;
  end
  initial begin
    #100000;
    errors++;
    stop_test();
  end
  task automatic stop_test();
    $display("%0d checks %0d errors", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Read one register, optionally holding the access n extra cycles
  task automatic chk(input logic [7:0] a, exp, input int n = 0);
    i_host.acc(1'b0, a, 8'h00, n, d);
    checks++;
    if (d !== exp) begin
      errors++;
      $display("[ERR] %0t reg %h read %h want %h", $time, a, d, exp);
    end
  endtask
  // Compare a pulse count with its expected value
  task automatic chk_cnt(input int got, exp);
    checks++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %0t pulse count %0d want %0d", $time, got, exp);
    end
  endtask
  // Load {hour,day,weekday,month}, give one hour carry, read all back
  task automatic roll(input logic f, input logic [7:0] y, input logic [31:0] v, e);
    format_12h_i = f;
    year_i = y;
    for (int i = 0; i < 4; i++) i_host.acc(1'b1, HOUR_COUNTER_OFS + 8'(i), v[31-8*i -: 8], 0, d);
    @(negedge mclk_i) hour_carry_i = 1'b1;
    @(negedge mclk_i) hour_carry_i = 1'b0;
    for (int i = 0; i < 4; i++) chk(HOUR_COUNTER_OFS + 8'(i), e[31-8*i -: 8]);
  endtask
  // All-ones writes show the masks; a reset must not touch the counters
  task automatic t_regs();
    for (int i = 0; i < 4; i++) i_host.acc(1'b1, HOUR_COUNTER_OFS + 8'(i), 8'hff, 0, d);
    chk(HOUR_COUNTER_OFS, HOUR_MASK);
    chk(DAY_COUNTER_OFS, DAY_MASK);
    chk(WEEKDAY_COUNTER_OFS, WEEKDAY_MASK);
    chk(MONTH_COUNTER_OFS, MONTH_MASK);
    chk(8'h09, 8'h00);
    @(negedge mclk_i) rst_b_i = 1'b0;
    @(negedge mclk_i) rst_b_i = 1'b1;
    chk(HOUR_COUNTER_OFS, HOUR_MASK);
  endtask
  // Month lengths, leap years and the year end in 24-hour layout
  task automatic t_days();
    roll(1'b0, 8'h21, 32'h09_15_03_07, 32'h10_15_03_07);
    roll(1'b0, 8'h24, 32'h23_28_06_02, 32'h00_29_00_02);
    roll(1'b0, 8'h24, 32'h23_29_00_02, 32'h00_01_01_03);
    chk_cnt(week_cnt, 1);
    roll(1'b0, 8'h00, 32'h23_28_02_02, 32'h00_29_03_02);
    roll(1'b0, 8'h23, 32'h23_28_03_02, 32'h00_01_04_03);
    roll(1'b0, 8'h21, 32'h23_30_04_04, 32'h00_01_05_05);
    roll(1'b0, 8'h21, 32'h23_30_05_01, 32'h00_31_06_01);
    chk_cnt(month_cnt, 0);
    roll(1'b0, 8'h21, 32'h23_31_06_12, 32'h00_01_00_01);
    chk_cnt(month_cnt, 1);
    chk_cnt(week_cnt, 1);
  endtask
  // Noon and midnight in 12-hour layout; 12 PM goes on to 1 PM, not 13
  task automatic t_hours();
    roll(1'b1, 8'h21, 32'h11_05_03_07, 32'h32_05_03_07);
    roll(1'b1, 8'h21, 32'h31_05_03_07, 32'h12_06_04_07);
    roll(1'b1, 8'h21, 32'h32_05_03_07, 32'h21_05_03_07);
  endtask
  // Two carries inside one long read: only one may land after release
  task automatic t_freeze();
    roll(1'b0, 8'h21, 32'h08_15_03_07, 32'h09_15_03_07);
    fork
      chk(HOUR_COUNTER_OFS, 8'h09, 6);
      begin
        @(negedge mclk_i) hour_carry_i = 1'b1;
        @(negedge mclk_i) hour_carry_i = 1'b0;
        @(negedge mclk_i) hour_carry_i = 1'b1;
        @(negedge mclk_i) hour_carry_i = 1'b0;
      end
    join
    chk(HOUR_COUNTER_OFS, 8'h10);
  endtask
  initial begin
    week_cnt = 0;
    month_cnt = 0;
    rst_b_i = 1'b0;
    hour_carry_i = 1'b0;
    format_12h_i = 1'b0;
    year_i = 8'h00;
    repeat (8) @(negedge mclk_i);
    rst_b_i = 1'b1;
    t_regs();
    t_days();
    t_hours();
    t_freeze();
    stop_test();
  end
endmodule // testbench
